// File: bench/test_feac_receive_status_fifo.sv
/*
  self-checking bench for the far-end alarm code receiver: host register
  reads and writes, serial codewords and idle, fifo fill, overflow, soft reset
  and the interrupt request.
  assumes fcrx_rx with its defines header on the include path.
*/
`default_nettype none
`include "fcrx_defines.svh"
// compare one design value with its expectation and count the outcome
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_feac_receive_status_fifo;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ovh_bit = 1'b0;
  logic ovh_bit_valid = 1'b0;
  logic port_status_irq_en = 1'b0;
  logic [`FCRX_ADDR_W-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq;
  int miscompares = 0; // mismatches seen
  int comparisons = 0; // checks made
  fcrx_rx dut_u (
    .core_clk(core_clk), .rst(rst), .ovh_bit(ovh_bit),
    .ovh_bit_valid(ovh_bit_valid), .port_status_irq_en(port_status_irq_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );
  // 10 mhz clock
  always #50 core_clk = ~core_clk;
  // verdict and end of run, shared by the main flow and the watchdog
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // one overhead bit, a single valid pulse then a quiet cycle
  task automatic send_bit(input logic b);
    @(posedge core_clk);
    ovh_bit_valid <= 1'b1;
    ovh_bit <= b;
    @(posedge core_clk);
    ovh_bit_valid <= 1'b0;
    ovh_bit <= ~b; // not a held value: the line shows garbage off-strobe
  endtask
  // framed word in time order: eight ones, zero, c1..c6, zero
  task automatic send_word(input logic [5:0] c, input int n);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 0; i < 8; i++)
        send_bit(1'b1);
      send_bit(1'b0);
      for (int i = 0; i < 6; i++)
        send_bit(c[i]); // first bit sent lands in field bit 0
      send_bit(1'b0);
    end
  endtask
  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // state after reset
    rd_chk(`FCRX_OFS_LATCH, 16'h0001);
    rd_chk(`FCRX_OFS_LIVE, 16'h0008);
    rd_chk(`FCRX_OFS_FIFO, 16'h0080);
    rd_chk(`FCRX_OFS_CTRL, 16'h0000);
    rd_chk(`FCRX_OFS_IRQ_EN, 16'h0000);
    rd_chk(12'h0d2, 16'h0000);
    // interrupt needs latched bit, its enable and the port enable
    reg_write(`FCRX_OFS_IRQ_EN, 16'h0001);
    `CHK(irq, 1'b0)
    @(posedge core_clk);
    port_status_irq_en <= 1'b1;
    #1;
    `CHK(irq, 1'b1)
    reg_write(`FCRX_OFS_LATCH, 16'h0001);
    `CHK(irq, 1'b0)
    rd_chk(`FCRX_OFS_LATCH, 16'h0000);
    // all-ones channel is idle, not a codeword
    for (int i = 0; i < 16; i++)
      send_bit(1'b1);
    rd_chk(`FCRX_OFS_LIVE, 16'h0009);
    rd_chk(`FCRX_OFS_LATCH, 16'h0001);
    `CHK(irq, 1'b1)
    reg_write(`FCRX_OFS_IRQ_EN, 16'h0000);
    `CHK(irq, 1'b0)
    reg_write(`FCRX_OFS_LATCH, 16'h0007);
    // one word raises detect but is not yet stored
    send_word(6'h13, 1);
    rd_chk(`FCRX_OFS_LIVE, 16'h000a);
    rd_chk(`FCRX_OFS_LATCH, 16'h0002);
    rd_chk(`FCRX_OFS_FIFO, 16'h0080);
    send_word(6'h13, 1);
    rd_chk(`FCRX_OFS_LIVE, 16'h0002);
    rd_chk(`FCRX_OFS_FIFO, 16'h0013);
    rd_chk(`FCRX_OFS_FIFO, 16'h0080);
    // seventeen distinct codes into a sixteen-deep fifo
    reg_write(`FCRX_OFS_LATCH, 16'h0007);
    for (int i = 0; i < 17; i++)
      send_word(6'(i + 1), 2);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= `FCRX_OFS_LATCH;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & 16'h0004, 16'h0004)
    reg_write(`FCRX_OFS_IRQ_EN, 16'h0004);
    `CHK(irq, 1'b1)
    for (int i = 0; i < 16; i++)
      rd_chk(`FCRX_OFS_FIFO, 16'(i + 1));
    rd_chk(`FCRX_OFS_FIFO, 16'h0080);
    reg_write(`FCRX_OFS_IRQ_EN, 16'h0000);
    reg_write(`FCRX_OFS_LATCH, 16'h0007);
    // soft reset empties the fifo and drops incoming bits
    send_word(6'h21, 2);
    reg_write(`FCRX_OFS_CTRL, 16'h0001);
    rd_chk(`FCRX_OFS_CTRL, 16'h0001);
    rd_chk(`FCRX_OFS_LIVE, 16'h0008);
    send_word(6'h05, 2);
    rd_chk(`FCRX_OFS_LIVE, 16'h0008);
    rd_chk(`FCRX_OFS_FIFO, 16'h0080);
    reg_write(`FCRX_OFS_CTRL, 16'h0000);
    send_word(6'h05, 2);
    rd_chk(`FCRX_OFS_FIFO, 16'h0005);
    // idle ones after a codeword end the lock and raise idle
    for (int i = 0; i < 16; i++)
      send_bit(1'b1);
    rd_chk(`FCRX_OFS_LIVE, 16'h0009);
    rd_chk(`FCRX_OFS_LATCH, 16'h0003);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: logic/fcrx_defines.svh
/*
  constants of the far-end alarm code receiver: register offsets, field
  positions, reset values, code framing and fifo sizing.
  assumes byte offsets on the host register port as printed for the block.
*/
`ifndef FCRX_DEFINES_SVH
`define FCRX_DEFINES_SVH

// register offsets on the host port
`define FCRX_ADDR_W 12
`define FCRX_OFS_CTRL 12'h0d0
`define FCRX_OFS_LIVE 12'h0d4
`define FCRX_OFS_LATCH 12'h0d6
`define FCRX_OFS_IRQ_EN 12'h0d8
`define FCRX_OFS_FIFO 12'h0dc

// field positions
`define FCRX_BIT_SOFT_RESET 0
`define FCRX_BIT_EMPTY 3
`define FCRX_BIT_CODEWORD 1
`define FCRX_BIT_IDLE 0
`define FCRX_BIT_OVERFLOW 2
`define FCRX_BIT_INVALID 7

// reset values
`define FCRX_RST_CTRL 1'h0
`define FCRX_RST_IRQ_EN 3'h0
`define FCRX_RST_LATCH 3'h1

// code framing: eight ones, zero, six code bits, zero
`define FCRX_FLAG_BYTE 8'hff
`define FCRX_IDLE_WORD 16'hffff
`define FCRX_WORD_LAST 4'hf

// fifo depth in codes
`define FCRX_FIFO_DEPTH 16
`define FCRX_PTR_W 4

`endif

// File: logic/fcrx_pkg.sv
/*
  types shared by the far-end alarm code receiver.
  assumes fcrx_defines.svh for the numbers.
*/
`default_nettype none
package fcrx_pkg;
  // detector state: hunting for a codeword or locked on one
  typedef enum logic [1:0] {
    FCRX_HUNT = 2'b01,
    FCRX_LOCK = 2'b10
  } fcrx_state_e;
  typedef logic [5:0] fcrx_code_t;
endpackage
`default_nettype wire

// File: logic/fcrx_rx.sv
/*
  far-end alarm code receiver: serial overhead bit detector for codewords
  and idle, 16-deep code fifo, live and latched status, interrupt request.
  assumes one 10 mhz clock, a synchronous active-high reset, overhead bits
  arriving with a one-cycle valid, and a host port that reads one cycle late.
*/
// Added by the designer: the plain strobed port.
`default_nettype none
`include "fcrx_defines.svh"
module fcrx_rx
(
  input wire logic core_clk,
  input wire logic rst,
  // serial overhead stream from the framer
  input wire logic ovh_bit,
  input wire logic ovh_bit_valid,
  // per-port global status enable from the interrupt tree
  input wire logic port_status_irq_en,
  // host register port
  input wire logic [`FCRX_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq
);
  // shift register of received bits, newest in bit 0
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  fcrx_pkg::fcrx_state_e state_q;
  fcrx_pkg::fcrx_state_e state_d;
  logic [3:0] bit_cnt_q; // bit position inside a locked word
  fcrx_pkg::fcrx_code_t last_code_q; // code of the previous word
  logic stored_q; // current run already put in the fifo
  logic idle_q; // live idle status
  logic cw_prev_q; // codeword status one cycle ago
  logic idle_prev_q; // idle status one cycle ago
  // registers
  logic soft_rst_q;
  logic [2:0] irq_en_q;
  logic [2:0] latch_q;
  logic [2:0] latch_d;
  // fifo
  fcrx_pkg::fcrx_code_t mem [`FCRX_FIFO_DEPTH];
  logic [`FCRX_PTR_W-1:0] wptr_q;
  logic [`FCRX_PTR_W-1:0] rptr_q;
  logic [`FCRX_PTR_W:0] count_q;

  // address decode
  wire sel_ctrl = reg_addr == `FCRX_OFS_CTRL;
  wire sel_live = reg_addr == `FCRX_OFS_LIVE;
  wire sel_latch = reg_addr == `FCRX_OFS_LATCH;
  wire sel_irq_en = reg_addr == `FCRX_OFS_IRQ_EN;
  wire sel_fifo = reg_addr == `FCRX_OFS_FIFO;

  // incoming bit is dropped while the soft reset holds
  wire bit_take = ovh_bit_valid && !soft_rst_q;
  assign shift_d = {shift_q[14:0], ovh_bit};
  // codeword frame: flag byte, zero, six code bits, zero
  wire cw_match = shift_d[15:8] == `FCRX_FLAG_BYTE && !shift_d[7]
    && !shift_d[0];
  // first received code bit (oldest) goes to field bit 0
  wire [5:0] cw_code = {shift_d[1], shift_d[2], shift_d[3], shift_d[4],
    shift_d[5], shift_d[6]};
  wire word_end = bit_cnt_q == `FCRX_WORD_LAST;
  wire locked = state_q == fcrx_pkg::FCRX_LOCK;

  // a code is pushed on the second identical word of a run
  wire push_req = bit_take && locked && word_end && cw_match
    && cw_code == last_code_q && !stored_q;
  wire fifo_empty = count_q == '0;
  wire fifo_full = count_q == (`FCRX_PTR_W+1)'(`FCRX_FIFO_DEPTH);
  wire do_push = push_req && !fifo_full;
  wire overflow = push_req && fifo_full;
  wire do_pop = reg_rd && sel_fifo && !fifo_empty;

  // live status and its rising edges
  wire cw_active = locked;
  wire cw_rise = cw_active && !cw_prev_q;
  wire idle_rise = idle_q && !idle_prev_q;
  wire [2:0] latch_set = {overflow, cw_rise, idle_rise};
  wire [2:0] latch_clr = (reg_wr && sel_latch) ? reg_wdata[2:0] : 3'h0;
  // bits that survive this cycle's clear; watched by the sticky check
  wire [2:0] latch_keep = latch_q & ~latch_clr;
  // set beats a clear in the same cycle
  assign latch_d = (latch_q & ~latch_clr) | latch_set;

  // request only when latched, enabled and the port enable is set
  assign irq = |(latch_q & irq_en_q) && port_status_irq_en;

  // read data mux
  wire [15:0] live_word = {12'h000, fifo_empty, 1'b0, cw_active, idle_q};
  // an empty fifo shows a zero code, never a stale or unwritten entry
  wire [5:0] head_code = fifo_empty ? 6'h00 : mem[rptr_q];
  wire [15:0] fifo_word = {8'h00, fifo_empty, 1'b0, head_code};
  wire [15:0] rd_mux = sel_ctrl ? {15'h0000, soft_rst_q} :
    sel_live ? live_word :
    sel_latch ? {13'h0000, latch_q} :
    sel_irq_en ? {13'h0000, irq_en_q} :
    sel_fifo ? fifo_word : 16'h0000;

  // detector next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      fcrx_pkg::FCRX_HUNT:
      begin
        // lock on the first framed word
        if (bit_take && cw_match)
          state_d = fcrx_pkg::FCRX_LOCK;
      end
      fcrx_pkg::FCRX_LOCK:
      begin
        // a broken frame, or idle ones, drops the lock
        if (bit_take && word_end && !cw_match)
          state_d = fcrx_pkg::FCRX_HUNT;
      end
      default:
        state_d = fcrx_pkg::FCRX_HUNT;
    endcase
  end

  // detector registers; soft reset holds them cleared
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst_q)
    begin
      shift_q <= 16'h0000;
      state_q <= fcrx_pkg::FCRX_HUNT;
      bit_cnt_q <= 4'h0;
      last_code_q <= 6'h00;
      stored_q <= 1'b0;
      idle_q <= 1'b0;
    end
    else if (bit_take)
    begin
      shift_q <= shift_d;
      state_q <= state_d;
      idle_q <= shift_d == `FCRX_IDLE_WORD;
      // count restarts at each framed word boundary
      bit_cnt_q <= (state_d == fcrx_pkg::FCRX_LOCK && (word_end || !locked))
        ? 4'h0 : bit_cnt_q + 4'h1;
      if (cw_match && (word_end || !locked))
      begin
        // a new code value starts a new run
        stored_q <= locked && cw_code == last_code_q;
        last_code_q <= cw_code;
      end
    end
  end

  // edge history for the latched bits
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cw_prev_q <= 1'b0;
      idle_prev_q <= 1'b0;
    end
    else
    begin
      cw_prev_q <= cw_active;
      idle_prev_q <= idle_q;
    end
  end

  // software registers; latched idle comes up set
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      soft_rst_q <= `FCRX_RST_CTRL;
      irq_en_q <= `FCRX_RST_IRQ_EN;
      latch_q <= `FCRX_RST_LATCH;
    end
    else
    begin
      latch_q <= latch_d;
      if (reg_wr && sel_ctrl)
        soft_rst_q <= reg_wdata[`FCRX_BIT_SOFT_RESET];
      if (reg_wr && sel_irq_en)
        irq_en_q <= reg_wdata[2:0];
    end
  end

  // fifo storage has no reset; only the pointers matter
  always_ff @(posedge core_clk)
  begin
    if (do_push)
      mem[wptr_q] <= cw_code;
  end

  // fifo pointers; soft reset empties the fifo
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst_q)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_push)
        wptr_q <= wptr_q + 1'b1;
      if (do_pop)
        rptr_q <= rptr_q + 1'b1;
      // push and pop together leave the count alone
      if (do_push && !do_pop)
        count_q <= count_q + 1'b1;
      else if (do_pop && !do_push)
        count_q <= count_q - 1'b1;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_soft_reset_empties;
    soft_rst_q |=> fifo_empty && !cw_active && !idle_q;
  endproperty
  a_soft_reset_empties: assert property (p_soft_reset_empties)
    else $error("soft reset left fifo or detector busy");

  property p_empty_tracks;
    reg_rd && sel_live |=> reg_rdata[`FCRX_BIT_EMPTY] == (count_q == '0)
      || $past(do_push) || $past(do_pop);
  endproperty
  a_empty_tracks: assert property (p_empty_tracks)
    else $error("live empty bit disagrees with fifo");

  property p_overflow_sets;
    overflow |=> latch_q[`FCRX_BIT_OVERFLOW] && count_q == $past(count_q)
      - (`FCRX_PTR_W+1)'($past(do_pop));
  endproperty
  a_overflow_sets: assert property (p_overflow_sets)
    else $error("overflow not latched or code stored");

  property p_cw_latch;
    $rose(cw_active) |=> latch_q[`FCRX_BIT_CODEWORD];
  endproperty
  a_cw_latch: assert property (p_cw_latch)
    else $error("codeword rise not latched");

  property p_idle_latch;
    $rose(idle_q) |=> latch_q[`FCRX_BIT_IDLE];
  endproperty
  a_idle_latch: assert property (p_idle_latch)
    else $error("idle rise not latched");

  property p_idle_after_reset;
    $past(rst) |-> latch_q[`FCRX_BIT_IDLE];
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("latched idle not set after reset");

  property p_irq_gate;
    irq == (port_status_irq_en && (latch_q & irq_en_q) != 3'h0);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enabled latched bit");

  property p_invalid_flag;
    reg_rd && sel_fifo |=> reg_rdata[`FCRX_BIT_INVALID] == $past(fifo_empty);
  endproperty
  a_invalid_flag: assert property (p_invalid_flag)
    else $error("fifo invalid flag wrong");

  sequence s_pop;
    reg_rd && sel_fifo && !fifo_empty && !do_push && !soft_rst_q;
  endsequence
  property p_pop_advances;
    s_pop |=> count_q == $past(count_q) - 1'b1
      && rptr_q == $past(rptr_q) + 1'b1;
  endproperty
  a_pop_advances: assert property (p_pop_advances)
    else $error("fifo read did not pop");

  sequence s_store;
    do_push && fifo_empty && !soft_rst_q;
  endsequence
  property p_store_order;
    s_store ##1 (reg_rd && sel_fifo) |=> reg_rdata[5:0] == $past(cw_code, 2)
      && !reg_rdata[`FCRX_BIT_INVALID];
  endproperty
  a_store_order: assert property (p_store_order)
    else $error("stored code not presented");

  // a clear writes ones only; untouched latched bits stay set
  property p_latch_keep;
    latch_keep != 3'h0 |=> (latch_q & $past(latch_keep)) == $past(latch_keep);
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("latched bit lost without a clear");

  // an event wins over a clear of the same bit in the same cycle
  property p_set_wins;
    latch_set != 3'h0 |=> (latch_q & $past(latch_set)) == $past(latch_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("latched event lost to a clear");

  // live idle follows the last sixteen taken bits
  property p_idle_live;
    idle_q == (shift_q == `FCRX_IDLE_WORD);
  endproperty
  a_idle_live: assert property (p_idle_live)
    else $error("live idle bit disagrees with channel");

  // idle ones at a word boundary end the codeword and count as idle
  property p_idle_drops_lock;
    locked && bit_take && word_end && shift_d == `FCRX_IDLE_WORD
      |=> !cw_active && idle_q;
  endproperty
  a_idle_drops_lock: assert property (p_idle_drops_lock)
    else $error("idle ones taken for a codeword");

  // a broken frame at a word boundary ends the live codeword status
  property p_cw_drop;
    locked && bit_take && word_end && !cw_match |=> !cw_active;
  endproperty
  a_cw_drop: assert property (p_cw_drop)
    else $error("codeword status kept after broken frame");

  // only the validating word of a run may store its code
  property p_push_locked;
    do_push |-> locked && word_end && cw_match && !stored_q;
  endproperty
  a_push_locked: assert property (p_push_locked)
    else $error("code stored without validation");

  // the fill level never passes the depth; extra codes are dropped
  property p_count_bound;
    count_q <= (`FCRX_PTR_W+1)'(`FCRX_FIFO_DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("fifo fill level beyond depth");

  // reading an empty fifo must not underflow the pointers
  property p_empty_read_safe;
    reg_rd && sel_fifo && fifo_empty && !do_push |=> fifo_empty;
  endproperty
  a_empty_read_safe: assert property (p_empty_read_safe)
    else $error("read of empty fifo changed its level");

  // nothing enters the detector or the fifo while soft reset holds
  property p_soft_drops;
    soft_rst_q |-> !bit_take && !do_push && !overflow;
  endproperty
  a_soft_drops: assert property (p_soft_drops)
    else $error("input taken during soft reset");

  // leaving soft reset starts from an empty fifo and a fresh hunt
  property p_resume;
    $fell(soft_rst_q) |-> fifo_empty && state_q == fcrx_pkg::FCRX_HUNT;
  endproperty
  a_resume: assert property (p_resume)
    else $error("detector not clean after soft reset");
endmodule
`default_nettype wire
